// File: core/asgf_pkg.sv
// Constants and types shared by the signalling group framer
package asgf_pkg;

    // ********************************************************
    // Group layout
    // ********************************************************
    localparam int          GROUP_BYTES   = 8;
    localparam int          GROUP_W       = 64;
    localparam int          FIFO_DEPTH    = 8;
    localparam logic [7:0]  CODE_MARK     = 8'hc0;
    localparam logic [7:0]  CODE_MARK_MSK = 8'hc0;
    localparam logic [3:0]  NIB_START     = 4'h0;
    localparam logic [3:0]  NIB_CONT      = 4'h3;
    localparam logic [3:0]  NIB_END       = 4'hc;
    localparam logic [3:0]  NIB_PAD       = 4'hf;
    localparam logic [7:0]  RFU_BYTE      = 8'h00;
    localparam logic [7:0]  FILL_BYTE     = 8'hff;
    localparam logic [2:0]  POS_START_DAT = 3'h4;
    localparam logic [2:0]  POS_CONT_DAT  = 3'h2;
    localparam logic [2:0]  POS_LAST_FULL = 3'h7;
    localparam logic [2:0]  POS_LAST_END  = 3'h5;
    localparam logic [3:0]  CRC_ALL_BYTES = 4'h8;
    localparam logic [3:0]  CRC_END_BYTES = 4'h6;
    localparam logic [2:0]  NB_SHORT      = 3'h4;
    localparam logic [2:0]  NB_CONT       = 3'h6;
    localparam logic [15:0] CRC_POLY_DEF  = 16'h1021;
    localparam logic [15:0] CRC_INIT_DEF  = 16'hffff;
    localparam logic [63:0] PAD_GROUP     = {CODE_MARK | {4'h0, NIB_PAD}, {7{FILL_BYTE}}};

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        ASGF_K_START,
        ASGF_K_CONT,
        ASGF_K_END,
        ASGF_K_PAD,
        ASGF_K_BAD
    } asgf_kind_t;

    typedef struct packed {
        logic [6:0] msg_type;
        logic       user_defined;
        logic [7:0] continuation_group_count;
    } asgf_tx_hdr_t;

    typedef struct packed {
        asgf_kind_t  kind;
        logic [7:0]  msg_type;
        logic [7:0]  continuation_group_count;
        logic [2:0]  nbytes;
        logic [47:0] data;
    } asgf_rx_info_t;

    function automatic asgf_kind_t asgf_decode(input logic [7:0] code);
        asgf_kind_t k;
        k = ASGF_K_BAD;
        if ((code & CODE_MARK_MSK) == CODE_MARK) begin
            unique case (code[3:0])
                NIB_START: k = ASGF_K_START;
                NIB_CONT:  k = ASGF_K_CONT;
                NIB_END:   k = ASGF_K_END;
                NIB_PAD:   k = ASGF_K_PAD;
                default:   k = ASGF_K_BAD;
            endcase
        end
        return k;
    endfunction

    function automatic logic [7:0] asgf_code(input logic [3:0] nib);
        return CODE_MARK | {4'h0, nib};
    endfunction

endpackage

// File: core/asgf_crc.sv
// Bytewise CRC-16 over the leading bytes of one group
`timescale 1ns/1ns
module asgf_crc #(
    parameter logic [15:0] POLY = asgf_pkg::CRC_POLY_DEF
) (
    input  wire logic [15:0] crc_in,
    input  wire logic [63:0] data_in,
    input  wire logic [3:0]  nbytes_in,
    output logic      [15:0] crc_out
);
    import asgf_pkg::*;

    // Byte 0 sits in the top lane and is folded in first, MSB first
    always_comb begin
        logic [15:0] c;
        logic        fb;
        c  = crc_in;
        fb = 1'b0;
        for (int b = 0; b < GROUP_BYTES; b++) begin
            if (4'(b) < nbytes_in) begin
                for (int k = 0; k < 8; k++) begin
                    fb = c[15] ^ data_in[GROUP_W - 1 - 8 * b - k];
                    c  = {c[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
                end
            end
        end
        crc_out = c;
    end

endmodule

// File: core/asgf_fifo.sv
// Group FIFO with a registered output stage
`timescale 1ns/1ns
module asgf_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    import asgf_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready_out = (count_reg != CW'(DEPTH));
    assign push         = in_valid_in && in_ready_out;
    // Refill the output stage whenever it is empty or being drained
    assign pop          = (count_reg != '0) && (!out_valid_out || out_ready_in);

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ptr_inc(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= ptr_inc(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= CW'(count_reg + 1'b1);
            end else if (pop && !push) begin
                count_reg <= CW'(count_reg - 1'b1);
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem_reg[rd_ptr_reg];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end

endmodule

// File: core/asgf_framer.sv
// Asynchronous signalling message framer and parser over 8-byte groups
// Functional notes
// - Byte 0 codes start, continuation, end, padding
// - Message begins with one start group
// - Start carries type and continuation count
// - Continuation: code, reserved, six data bytes
// - End: code, reserved, four data, CRC
// - Padding group carries code then FF bytes
// - Type bit 0 marks user-definable type
// - Padding groups never counted as continuations
// - Non-padding groups equal count plus two
// - CRC spans start byte 0 to end byte 5
`timescale 1ns/1ns
module asgf_framer #(
    parameter logic [15:0] CRC_POLY = asgf_pkg::CRC_POLY_DEF,
    parameter logic [15:0] CRC_INIT = asgf_pkg::CRC_INIT_DEF
) (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   tx_msg_valid_in,
    input  wire asgf_pkg::asgf_tx_hdr_t tx_msg_hdr_in,
    output logic                        tx_msg_ready_out,
    input  wire logic                   tx_byte_valid_in,
    input  wire logic [7:0]             tx_byte_in,
    output logic                        tx_byte_ready_out,
    input  wire logic                   tx_pad_req_in,
    output logic                        tx_group_valid_out,
    output logic [63:0]                 tx_group_out,
    input  wire logic                   tx_group_ready_in,
    input  wire logic                   rx_group_valid_in,
    input  wire logic [63:0]            rx_group_in,
    output logic                        rx_group_ready_out,
    output logic                        rx_valid_out,
    output asgf_pkg::asgf_rx_info_t     rx_info_out,
    output logic                        rx_crc_err_out,
    output logic                        rx_seq_err_out
);
    import asgf_pkg::*;

    // ********************************************************
    // Transmit side
    // ********************************************************
    typedef enum logic [1:0] {
        ASGF_TX_IDLE,
        ASGF_TX_FILL,
        ASGF_TX_PUSH,
        ASGF_TX_PAD
    } asgf_tx_state_t;

    asgf_tx_state_t state_reg;
    asgf_tx_state_t state_next;
    asgf_kind_t     kind_reg;
    logic [2:0]     pos_reg;
    logic [7:0]     cont_left_reg;
    logic [63:0]    grp_reg;
    logic [15:0]    tx_crc_reg;
    logic [15:0]    tx_crc_calc;
    logic [63:0]    fifo_in_data;
    logic           fifo_in_valid;
    logic           fifo_in_ready;
    logic           msg_take;
    logic           byte_take;
    logic           last_byte;

    assign msg_take  = tx_msg_valid_in && tx_msg_ready_out;
    assign byte_take = tx_byte_valid_in && tx_byte_ready_out;
    assign last_byte = (kind_reg == ASGF_K_END) ? (pos_reg == POS_LAST_END)
                                                : (pos_reg == POS_LAST_FULL);

    // End group folds only bytes 0..5 into the checksum
    asgf_crc #(
        .POLY      (CRC_POLY)
    ) u_tx_crc (
        .crc_in    (tx_crc_reg),
        .data_in   (grp_reg),
        .nbytes_in ((kind_reg == ASGF_K_END) ? CRC_END_BYTES : CRC_ALL_BYTES),
        .crc_out   (tx_crc_calc)
    );

    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data  = grp_reg;
        if (state_reg == ASGF_TX_PUSH) begin
            fifo_in_valid = 1'b1;
            if (kind_reg == ASGF_K_END) begin
                fifo_in_data = {grp_reg[63:16], tx_crc_calc};
            end
        end else if (state_reg == ASGF_TX_PAD) begin
            fifo_in_valid = 1'b1;
            fifo_in_data  = PAD_GROUP;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ASGF_TX_IDLE: begin
                if (msg_take) begin
                    state_next = ASGF_TX_FILL;
                end else if (tx_pad_req_in) begin
                    state_next = ASGF_TX_PAD;
                end
            end
            ASGF_TX_FILL: begin
                if (byte_take && last_byte) begin
                    state_next = ASGF_TX_PUSH;
                end
            end
            ASGF_TX_PUSH: begin
                if (fifo_in_ready) begin
                    state_next = (kind_reg == ASGF_K_END) ? ASGF_TX_IDLE : ASGF_TX_FILL;
                end
            end
            ASGF_TX_PAD: begin
                if (fifo_in_ready) begin
                    state_next = ASGF_TX_IDLE;
                end
            end
        endcase
    end

    // Handshake readies are registered copies of the next state
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            state_reg         <= ASGF_TX_IDLE;
            tx_msg_ready_out  <= 1'b0;
            tx_byte_ready_out <= 1'b0;
        end else begin
            state_reg         <= state_next;
            tx_msg_ready_out  <= (state_next == ASGF_TX_IDLE);
            tx_byte_ready_out <= (state_next == ASGF_TX_FILL);
        end
    end

    // Group assembly
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            kind_reg      <= ASGF_K_START;
            pos_reg       <= '0;
            cont_left_reg <= '0;
            grp_reg       <= '0;
        end else if (msg_take) begin
            kind_reg      <= ASGF_K_START;
            pos_reg       <= POS_START_DAT;
            cont_left_reg <= tx_msg_hdr_in.continuation_group_count;
            grp_reg       <= {asgf_code(NIB_START), RFU_BYTE,
                              tx_msg_hdr_in.msg_type, tx_msg_hdr_in.user_defined,
                              tx_msg_hdr_in.continuation_group_count, 32'h0000_0000};
        end else if (byte_take) begin
            grp_reg[{3'(3'h7 - pos_reg), 3'h0} +: 8] <= tx_byte_in;
            pos_reg <= 3'(pos_reg + 1'b1);
        end else if (state_reg == ASGF_TX_PUSH && fifo_in_ready && kind_reg != ASGF_K_END) begin
            // Count runs down once per continuation; padding never touches it
            pos_reg <= POS_CONT_DAT;
            grp_reg <= '0;
            if (cont_left_reg != '0) begin
                kind_reg              <= ASGF_K_CONT;
                cont_left_reg         <= 8'(cont_left_reg - 1'b1);
                grp_reg[63:48]        <= {asgf_code(NIB_CONT), RFU_BYTE};
            end else begin
                kind_reg              <= ASGF_K_END;
                grp_reg[63:48]        <= {asgf_code(NIB_END), RFU_BYTE};
            end
        end
    end

    // Running checksum across message groups only
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            tx_crc_reg <= CRC_INIT;
        end else if (msg_take) begin
            tx_crc_reg <= CRC_INIT;
        end else if (state_reg == ASGF_TX_PUSH && fifo_in_ready) begin
            tx_crc_reg <= tx_crc_calc;
        end
    end

    // Absorbs bursts while the transport stalls; full FIFO stalls the assembler
    asgf_fifo #(
        .WIDTH         (GROUP_W),
        .DEPTH         (FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (fifo_in_valid),
        .in_data_in    (fifo_in_data),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (tx_group_valid_out),
        .out_data_out  (tx_group_out),
        .out_ready_in  (tx_group_ready_in)
    );

    // ********************************************************
    // Receive side
    // ********************************************************
    asgf_kind_t  rx_kind;
    logic        rx_take;
    logic        rx_in_msg_reg;
    logic [7:0]  rx_left_reg;
    logic [15:0] rx_crc_reg;
    logic [15:0] rx_crc_calc;

    assign rx_take = rx_group_valid_in && rx_group_ready_out;
    assign rx_kind = asgf_decode(rx_group_in[63:56]);

    asgf_crc #(
        .POLY      (CRC_POLY)
    ) u_rx_crc (
        .crc_in    ((rx_kind == ASGF_K_START) ? CRC_INIT : rx_crc_reg),
        .data_in   (rx_group_in),
        .nbytes_in ((rx_kind == ASGF_K_END) ? CRC_END_BYTES : CRC_ALL_BYTES),
        .crc_out   (rx_crc_calc)
    );

    // Parser never stalls the transport: one group per cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rx_group_ready_out <= 1'b0;
        end else begin
            rx_group_ready_out <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rx_in_msg_reg <= 1'b0;
            rx_left_reg   <= '0;
            rx_crc_reg    <= CRC_INIT;
        end else if (rx_take) begin
            unique case (rx_kind)
                ASGF_K_START: begin
                    // A fresh start abandons any message in progress
                    rx_in_msg_reg <= 1'b1;
                    rx_left_reg   <= rx_group_in[39:32];
                    rx_crc_reg    <= rx_crc_calc;
                end
                ASGF_K_CONT: begin
                    if (rx_in_msg_reg && rx_left_reg != '0) begin
                        rx_left_reg <= 8'(rx_left_reg - 1'b1);
                        rx_crc_reg  <= rx_crc_calc;
                    end else begin
                        rx_in_msg_reg <= 1'b0;
                    end
                end
                ASGF_K_END: begin
                    rx_in_msg_reg <= 1'b0;
                end
                ASGF_K_PAD: begin
                    rx_in_msg_reg <= rx_in_msg_reg;
                end
                default: begin
                    rx_in_msg_reg <= 1'b0;
                end
            endcase
        end
    end

    // Delivered group contents and event pulses
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rx_valid_out   <= 1'b0;
            rx_info_out    <= '0;
            rx_crc_err_out <= 1'b0;
            rx_seq_err_out <= 1'b0;
        end else begin
            rx_valid_out   <= 1'b0;
            rx_crc_err_out <= 1'b0;
            rx_seq_err_out <= 1'b0;
            if (rx_take) begin
                rx_info_out.kind                     <= rx_kind;
                rx_info_out.msg_type                 <= '0;
                rx_info_out.continuation_group_count <= '0;
                unique case (rx_kind)
                    ASGF_K_START: begin
                        rx_valid_out                         <= 1'b1;
                        rx_seq_err_out                       <= rx_in_msg_reg;
                        rx_info_out.msg_type                 <= rx_group_in[47:40];
                        rx_info_out.continuation_group_count <= rx_group_in[39:32];
                        rx_info_out.nbytes                   <= NB_SHORT;
                        rx_info_out.data                     <= {rx_group_in[31:0], 16'h0000};
                    end
                    ASGF_K_CONT: begin
                        rx_valid_out       <= rx_in_msg_reg && (rx_left_reg != '0);
                        rx_seq_err_out     <= !(rx_in_msg_reg && (rx_left_reg != '0));
                        rx_info_out.nbytes <= NB_CONT;
                        rx_info_out.data   <= rx_group_in[47:0];
                    end
                    ASGF_K_END: begin
                        // End is only where the count says it must be
                        rx_valid_out       <= rx_in_msg_reg && (rx_left_reg == '0);
                        rx_seq_err_out     <= !(rx_in_msg_reg && (rx_left_reg == '0));
                        rx_crc_err_out     <= rx_in_msg_reg && (rx_left_reg == '0)
                                              && (rx_crc_calc != rx_group_in[15:0]);
                        rx_info_out.nbytes <= NB_SHORT;
                        rx_info_out.data   <= {rx_group_in[47:16], 16'h0000};
                    end
                    ASGF_K_PAD: begin
                        rx_valid_out <= 1'b0;
                    end
                    default: begin
                        rx_seq_err_out <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// File: bench/asgf_framer_asserts.sv
// Concurrent checks on the signalling group framer ports
`timescale 1ns/1ns
module asgf_framer_chk
    import asgf_pkg::*;
(
    input wire logic           core_clk_in,
    input wire logic           rst_b_in,
    input wire logic           tx_msg_valid_in,
    input wire asgf_tx_hdr_t   tx_msg_hdr_in,
    input wire logic           tx_msg_ready_out,
    input wire logic           tx_byte_valid_in,
    input wire logic [7:0]     tx_byte_in,
    input wire logic           tx_byte_ready_out,
    input wire logic           tx_pad_req_in,
    input wire logic           tx_group_valid_out,
    input wire logic [63:0]    tx_group_out,
    input wire logic           tx_group_ready_in,
    input wire logic           rx_group_valid_in,
    input wire logic [63:0]    rx_group_in,
    input wire logic           rx_group_ready_out,
    input wire logic           rx_valid_out,
    input wire asgf_rx_info_t  rx_info_out,
    input wire logic           rx_crc_err_out,
    input wire logic           rx_seq_err_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic rx_take;
    assign rx_take = rx_group_valid_in && rx_group_ready_out;

    chk_code_mark: assert property (tx_group_valid_out |-> tx_group_out[63:62] == 2'b11 &&
        tx_group_out[59:56] inside {4'h0, 4'h3, 4'hc, 4'hf}) else $error("tx group code byte malformed");
    chk_start_rsvd: assert property (tx_group_valid_out && tx_group_out[59:56] == 4'h0
        |-> tx_group_out[55:48] == 8'h00) else $error("start group reserved byte not zero");
    chk_pad_fill: assert property (tx_group_valid_out && tx_group_out[59:56] == 4'hf
        |-> tx_group_out[55:0] == {7{8'hff}}) else $error("padding group not filled");
    chk_group_hold: assert property (tx_group_valid_out && !tx_group_ready_in
        |=> tx_group_valid_out && $stable(tx_group_out)) else $error("tx group dropped while stalled");
    chk_msg_busy: assert property (tx_msg_valid_in && tx_msg_ready_out |=> !tx_msg_ready_out [*2])
        else $error("second message taken too early");
    chk_rx_start: assert property (rx_take && rx_group_in[63:56] == 8'hc0 |=> rx_info_out.kind == ASGF_K_START
        && rx_info_out.msg_type == $past(rx_group_in[47:40])
        && rx_info_out.continuation_group_count == $past(rx_group_in[39:32])) else $error("start fields wrong");
    chk_rx_pad: assert property (rx_take && rx_group_in[63:56] == 8'hcf
        |=> !rx_valid_out && !rx_seq_err_out) else $error("padding group not discarded");
    chk_rx_cont: assert property (rx_take && rx_group_in[63:56] == 8'hc3 |=> rx_info_out.kind == ASGF_K_CONT
        && rx_info_out.nbytes == 3'h6 && rx_info_out.data == $past(rx_group_in[47:0]))
        else $error("continuation fields wrong");
    chk_rx_end: assert property (rx_take && rx_group_in[63:56] == 8'hcc |=> rx_info_out.kind == ASGF_K_END
        && rx_info_out.data[47:16] == $past(rx_group_in[47:16])) else $error("end fields wrong");
    chk_crc_end: assert property (rx_crc_err_out |-> rx_valid_out && rx_info_out.kind == ASGF_K_END)
        else $error("crc error outside end group");
endmodule

bind asgf_framer asgf_framer_chk u_chk (.*);

// File: bench/asgf_transport_model.sv
// Signalling channel transport: takes tx groups, logs them and loops them back
`timescale 1ns/1ns
module asgf_transport_model (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        slow_in,
    input  wire logic        flip_in,
    input  wire logic        grp_valid_in,
    input  wire logic [63:0] grp_in,
    output logic             grp_ready_out,
    output logic             rx_valid_out,
    output logic      [63:0] rx_grp_out,
    input  wire logic        rx_ready_in
);
    logic [63:0] seen[$];
    logic        stall_reg;
    always @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            grp_ready_out <= 1'b0;
            rx_valid_out <= 1'b0;
            stall_reg <= 1'b0;
            rx_grp_out <= '0;
        end else begin
            // Slow mode stalls every other cycle
            stall_reg <= ~stall_reg;
            grp_ready_out <= !slow_in || stall_reg;
            rx_valid_out <= ((grp_valid_in && grp_ready_out) || slow_in) && rx_ready_in;
            if (grp_valid_in && grp_ready_out) begin
                seen.push_back(grp_in);
                // Corrupting byte 2 only when the bench asks, so the checksum must trip
                rx_grp_out <= flip_in ? grp_in ^ 64'h0000ff0000000000 : grp_in;
            end else begin
                // Idle line inverts; slow mode slips padding in mid-message
                rx_grp_out <= slow_in ? {8'hcf, {7{8'hff}}} : ~rx_grp_out;
            end
        end
    end
endmodule

// File: bench/asgf_framer_tb.sv
// Self-checking bench for the signalling group framer
`timescale 1ns/1ns
module asgf_framer_tb;
    import asgf_pkg::*;
    localparam logic [15:0] POLY = 16'h1021;
    localparam logic [15:0] SEED = 16'hffff;
    logic          clk = 0, rst_b = 0, slow = 0, flip = 0, msg_v = 0, byte_v = 0, pad_req = 0;
    asgf_tx_hdr_t  hdr = '0;
    logic [7:0]    byte_d = 8'h00;
    logic          msg_r, byte_r, gv, gr, rv, rr, ov, crc_e, seq_e;
    logic [63:0]   gd, rd;
    asgf_rx_info_t info;
    int            fails = 0, check_count = 0, cyc = 0, n_ok = 0, n_crc = 0, n_seq = 0, npad = 0;
    always #5 clk = ~clk;

    asgf_framer #(.CRC_POLY(POLY), .CRC_INIT(SEED)) DUT (.core_clk_in(clk), .rst_b_in(rst_b),
        .tx_msg_valid_in(msg_v), .tx_msg_hdr_in(hdr), .tx_msg_ready_out(msg_r), .tx_byte_valid_in(byte_v),
        .tx_byte_in(byte_d), .tx_byte_ready_out(byte_r), .tx_pad_req_in(pad_req), .tx_group_valid_out(gv),
        .tx_group_out(gd), .tx_group_ready_in(gr), .rx_group_valid_in(rv), .rx_group_in(rd),
        .rx_group_ready_out(rr), .rx_valid_out(ov), .rx_info_out(info), .rx_crc_err_out(crc_e),
        .rx_seq_err_out(seq_e));
    asgf_transport_model u_far (.core_clk_in(clk), .rst_b_in(rst_b), .slow_in(slow), .flip_in(flip),
        .grp_valid_in(gv), .grp_in(gd), .grp_ready_out(gr), .rx_valid_out(rv), .rx_grp_out(rd), .rx_ready_in(rr));

    // ********************************************************
    // Monitors, timeout and shared tasks
    // ********************************************************
    always @(posedge clk) begin
        cyc++;
        if (ov === 1'b1) n_ok++;
        if (crc_e === 1'b1) n_crc++;
        if (seq_e === 1'b1) n_seq++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) r = r[15] ? {r[14:0], 1'b0} ^ POLY : {r[14:0], 1'b0};
        return r;
    endfunction

    // Hold the request until ready is seen, then release just after the taking edge
    task automatic hs(input bit is_byte);
        do @(negedge clk); while ((is_byte ? byte_r : msg_r) !== 1'b1);
        @(posedge clk);
        #1;
    endtask

    // Next logged non-padding group; padding groups are checked and counted on the way
    task automatic next_group(output logic [63:0] g);
        int w;
        forever begin
            w = 0;
            while (u_far.seen.size() == 0 && w < 500) begin
                @(negedge clk);
                w++;
            end
            if (u_far.seen.size() == 0) begin
                g = '0;
                return;
            end
            g = u_far.seen.pop_front();
            if (g[63:56] != 8'hcf) return;
            npad++;
            chk("pad group", {8'hcf, {7{8'hff}}}, g);
        end
    endtask

    task automatic send_msg(input logic [6:0] t, input logic u, input int n, input int crc_exp);
        logic [7:0]  d[$];
        logic [63:0] eg[$];
        logic [63:0] g;
        logic [15:0] c;
        int          ok0, crc0;
        ok0 = n_ok;
        crc0 = n_crc;
        c = SEED;
        for (int i = 0; i < 8 + 6 * n; i++) d.push_back(8'(i + 16));
        eg.push_back({8'hc0, 8'h00, t, u, 8'(n), d[0], d[1], d[2], d[3]});
        for (int k = 0; k < n; k++)
            eg.push_back({8'hc3, 8'h00, d[4+6*k], d[5+6*k], d[6+6*k], d[7+6*k], d[8+6*k], d[9+6*k]});
        g = {8'hcc, 8'h00, d[4+6*n], d[5+6*n], d[6+6*n], d[7+6*n], 16'h0000};
        for (int k = 0; k <= n; k++)
            for (int b = 7; b >= 0; b--) c = crc_byte(c, eg[k][8*b +: 8]);
        for (int b = 7; b >= 2; b--) c = crc_byte(c, g[8*b +: 8]);
        eg.push_back({g[63:16], c});
        hdr = '{t, u, 8'(n)};
        msg_v = 1'b1;
        hs(1'b0);
        msg_v = 1'b0;
        byte_v = 1'b1;
        foreach (d[i]) begin
            byte_d = d[i];
            hs(1'b1);
        end
        byte_v = 1'b0;
        foreach (eg[k]) begin
            next_group(g);
            chk("tx group", eg[k], g);
        end
        repeat (6) @(posedge clk);
        #1;
        chk("rx groups", 64'(n + 2), 64'(n_ok - ok0));
        chk("crc errors", 64'(crc_exp), 64'(n_crc - crc0));
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_short();
        send_msg(7'h05, 1'b0, 0, 0);
    endtask

    task automatic t_long_stalled();
        slow = 1'b1;
        send_msg(7'h2a, 1'b1, 3, 0);
        slow = 1'b0;
    endtask

    task automatic t_padding();
        npad = 0;
        pad_req = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        pad_req = 1'b0;
        send_msg(7'h11, 1'b0, 1, 0);
        chk("pads seen", 1, npad > 0);
    endtask

    task automatic t_crc_error();
        flip = 1'b1;
        send_msg(7'h33, 1'b1, 1, 1);
        flip = 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_short();
        t_long_stalled();
        t_padding();
        t_crc_error();
        t_short();
        chk("sequence errors", 0, n_seq);
        end_sim();
    end
endmodule
